// [rtl/angsr_pkg.sv]
package angsr_pkg;
    // Register word addresses on the serial register port
    localparam logic [7:0] ADDR_CTRL = 8'h1E;
    localparam logic [7:0] ADDR_ANG = 8'h20;
    localparam logic [7:0] ADDR_STA = 8'h22;
    localparam logic [7:0] ADDR_ERR = 8'h24;
    localparam logic [7:0] ADDR_WARN = 8'h26;
    // Control word fields
    localparam int CTRL_SEL_LSB = 12;
    localparam int CTRL_CLS_BIT = 10;
    localparam int CTRL_CLW_BIT = 9;
    localparam int CTRL_CLE_BIT = 8;
    // Angle word fields
    localparam int ANG_FAULT_BIT = 14;
    localparam int ANG_UV_BIT = 13;
    localparam int ANG_PAR_BIT = 12;
    // Status word fields
    localparam int STA_DIE_LSB = 8;
    localparam int STA_ROT_BIT = 7;
    localparam int STA_ADONE_BIT = 5;
    localparam int STA_BDONE_BIT = 4;
    localparam int STA_LRUN_BIT = 3;
    localparam int STA_FRUN_BIT = 2;
    localparam int STA_BOOT_BIT = 1;
    localparam int STA_AOK_BIT = 0;
    // Error word fields
    localparam int ERR_WAR_BIT = 11;
    localparam int ERR_STF_BIT = 10;
    localparam int ERR_SUV_BIT = 3;
    localparam int ERR_RUV_BIT = 2;
    // Word tags in bits 15:12
    localparam logic [3:0] TAG_STA = 4'h8;
    localparam logic [3:0] TAG_ERR = 4'hA;
    localparam logic [3:0] TAG_WARN = 4'hB;
    // Trigger codes and action selections
    localparam logic [7:0] CODE_SELFTEST = 8'hB9;
    localparam logic [7:0] CODE_TURNS = 8'h46;
    localparam logic [7:0] CODE_HARD_RESET = 8'h5A;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_TURNS = 4'h4;
    localparam logic [3:0] SEL_HARD_RESET = 4'h7;
    localparam logic [3:0] SEL_FRONTEND = 4'h9;
    localparam logic [3:0] SEL_LOGIC = 4'hA;
    localparam logic [3:0] SEL_BOTH = 4'hB;
    // Reset values: only the reset-seen error bit is set
    localparam logic [11:0] ERR_RESET = 12'h001;
    localparam logic [11:0] WARN_RESET = 12'h000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] data;
    } angsr_req_s;

    typedef struct packed {
        logic [11:0] angle;
        logic locked;
        logic rot_dir;
        logic [1:0] die_index;
        logic supply_uv;
        logic regulator_uv;
        logic avg_fault;
        logic quad_fault;
        logic lock_lost;
        logic zero_to;
        logic nvm_uncorr;
        logic osc_fault;
        logic mag_low;
        logic nvm_loaded;
        logic boot_tests_done;
        logic [11:0] warn_events;
    } angsr_sense_s;

    typedef struct packed {
        logic logic_done;
        logic logic_fail;
        logic frontend_done;
        logic frontend_fail;
    } angsr_test_s;
endpackage

// [rtl/angsr_regs.sv]
`timescale 1ns/100ps
module angsr_regs
    import angsr_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire angsr_req_s reg_req_in,
    output logic [15:0] read_data_out,
    input wire angsr_sense_s sense_in,
    input wire logic [11:0] error_mask_in,
    input wire logic [11:0] warning_mask_in,
    input wire angsr_test_s test_in,
    output logic logic_selftest_start_out,
    output logic frontend_selftest_start_out,
    output logic turns_reset_out,
    output logic hard_reset_req_out,
    output logic fault_summary_out
);

    typedef enum logic [1:0] {BOOT_LOAD, BOOT_TEST, BOOT_DONE} angsr_boot_e;
    typedef enum logic [0:0] {ACT_IDLE, ACT_RUN} angsr_act_e;

    angsr_boot_e boot_state;
    angsr_boot_e next_boot_state;
    angsr_act_e act_state;
    angsr_act_e next_act_state;
    logic [3:0] action_select;
    logic action_done;
    logic boot_done;
    logic logic_selftest_running;
    logic frontend_selftest_running;
    logic [11:0] err_flags;
    logic [11:0] err_seen;
    logic [11:0] warn_flags;
    logic [11:0] warn_seen;
    logic lstart;
    logic fstart;
    logic tstart;
    logic hstart;

    ////////////////////////////////////////////////////////////////////////////
    // Register access decode

    wire ctrl_wr = reg_req_in.wr && (reg_req_in.addr == ADDR_CTRL);
    wire [3:0] wr_select = reg_req_in.data[15:CTRL_SEL_LSB];
    wire [7:0] wr_code = reg_req_in.data[7:0];
    wire clear_done_flags = ctrl_wr && reg_req_in.data[CTRL_CLS_BIT];
    wire clear_warning_flags = ctrl_wr && reg_req_in.data[CTRL_CLW_BIT];
    wire clear_error_flags = ctrl_wr && reg_req_in.data[CTRL_CLE_BIT];
    wire err_rd = reg_req_in.rd && (reg_req_in.addr == ADDR_ERR);
    wire warn_rd = reg_req_in.rd && (reg_req_in.addr == ADDR_WARN);

    // The trigger acts on the selection written in the same word
    wire is_test_sel = (wr_select == SEL_FRONTEND) || (wr_select == SEL_LOGIC)
                       || (wr_select == SEL_BOTH);
    wire trig_test = ctrl_wr && (wr_code == CODE_SELFTEST) && is_test_sel;
    wire trig_turns = ctrl_wr && (wr_code == CODE_TURNS) && (wr_select == SEL_TURNS);
    wire trig_hard = ctrl_wr && (wr_code == CODE_HARD_RESET)
                     && (wr_select == SEL_HARD_RESET);
    // A new trigger is ignored while self-tests still run
    wire trig_any = (trig_test || trig_turns || trig_hard) && (act_state == ACT_IDLE);
    wire start_logic = trig_any && trig_test && wr_select[1];
    wire start_frontend = trig_any && trig_test && wr_select[0];

    ////////////////////////////////////////////////////////////////////////////
    // Boot sequence

    always_comb begin
        next_boot_state = boot_state;
        unique case (boot_state)
            BOOT_LOAD: begin
                if (sense_in.nvm_loaded) begin
                    next_boot_state = BOOT_TEST;
                end
            end
            BOOT_TEST: begin
                if (sense_in.boot_tests_done) begin
                    next_boot_state = BOOT_DONE;
                end
            end
            BOOT_DONE: begin
                next_boot_state = BOOT_DONE;
            end
            default: begin
                next_boot_state = BOOT_LOAD;
            end
        endcase
    end

    wire boot_active = (boot_state != BOOT_DONE);
    wire boot_finish = (boot_state == BOOT_TEST) && sense_in.boot_tests_done;
    wire angle_valid = sense_in.locked && !boot_active;

    ////////////////////////////////////////////////////////////////////////////
    // Action sequencing

    wire logic_end = logic_selftest_running && test_in.logic_done;
    wire frontend_end = frontend_selftest_running && test_in.frontend_done;
    wire logic_left = logic_selftest_running && !test_in.logic_done;
    wire frontend_left = frontend_selftest_running && !test_in.frontend_done;
    wire tests_finish = (act_state == ACT_RUN) && !logic_left && !frontend_left;
    // Turns reset completes at once; hard reset never completes here
    wire action_complete = tests_finish || (trig_any && trig_turns);

    always_comb begin
        next_act_state = act_state;
        unique case (act_state)
            ACT_IDLE: begin
                if (start_logic || start_frontend) begin
                    next_act_state = ACT_RUN;
                end
            end
            ACT_RUN: begin
                if (tests_finish) begin
                    next_act_state = ACT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            boot_state <= BOOT_LOAD;
            act_state <= ACT_IDLE;
        end else begin
            boot_state <= next_boot_state;
            act_state <= next_act_state;
        end
    end

    // Selection follows each control write and clears when an action completes
    wire [3:0] next_action_select = action_complete ? SEL_NONE
                                    : (ctrl_wr ? wr_select : action_select);
    // Set wins over a clear written in the same cycle
    wire next_action_done = action_complete
                            || (action_done && !trig_any && !clear_done_flags);
    wire next_boot_done = boot_finish || (boot_done && !clear_done_flags);
    wire next_logic_run = start_logic || logic_left;
    wire next_frontend_run = start_frontend || frontend_left;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            action_select <= SEL_NONE;
            action_done <= 1'b0;
            boot_done <= 1'b0;
            logic_selftest_running <= 1'b0;
            frontend_selftest_running <= 1'b0;
            lstart <= 1'b0;
            fstart <= 1'b0;
            tstart <= 1'b0;
            hstart <= 1'b0;
        end else begin
            action_select <= next_action_select;
            action_done <= next_action_done;
            boot_done <= next_boot_done;
            logic_selftest_running <= next_logic_run;
            frontend_selftest_running <= next_frontend_run;
            lstart <= start_logic;
            fstart <= start_frontend;
            tstart <= trig_any && trig_turns;
            hstart <= trig_any && trig_hard;
        end
    end

    assign logic_selftest_start_out = lstart;
    assign frontend_selftest_start_out = fstart;
    assign turns_reset_out = tstart;
    assign hard_reset_req_out = hstart;

    ////////////////////////////////////////////////////////////////////////////
    // Latched warning and error flags

    wire warn_unmasked = |(warn_flags & ~warning_mask_in);
    wire suv = sense_in.supply_uv;
    wire ruv = sense_in.regulator_uv;
    wire undervoltage_live = (suv && !error_mask_in[ERR_SUV_BIT])
                             || (ruv && !error_mask_in[ERR_RUV_BIT]);

    wire [11:0] err_events = {
        warn_unmasked && !error_mask_in[ERR_WAR_BIT],
        (logic_end && test_in.logic_fail) || (frontend_end && test_in.frontend_fail),
        sense_in.avg_fault,
        sense_in.quad_fault,
        sense_in.lock_lost,
        sense_in.zero_to,
        sense_in.nvm_uncorr,
        sense_in.osc_fault,
        suv,
        ruv,
        sense_in.mag_low,
        1'b0
    };

    // Only bits captured by an earlier read are cleared; new events win
    wire [11:0] err_keep = clear_error_flags ? (err_flags & ~err_seen) : err_flags;
    wire [11:0] next_err = err_keep | err_events;
    wire [11:0] warn_keep = clear_warning_flags ? (warn_flags & ~warn_seen)
                            : warn_flags;
    wire [11:0] next_warn = warn_keep | sense_in.warn_events;
    wire [11:0] next_err_seen = err_rd ? err_flags
                                : (clear_error_flags ? 12'h000 : err_seen);
    wire [11:0] next_warn_seen = warn_rd ? warn_flags
                                 : (clear_warning_flags ? 12'h000 : warn_seen);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            err_flags <= ERR_RESET;
            err_seen <= 12'h000;
            warn_flags <= WARN_RESET;
            warn_seen <= 12'h000;
        end else begin
            err_flags <= next_err;
            err_seen <= next_err_seen;
            warn_flags <= next_warn;
            warn_seen <= next_warn_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read words

    wire fault_summary = |(err_flags & ~error_mask_in) || warn_unmasked;
    wire [14:0] ang_low = {fault_summary, undervoltage_live, 1'b0, sense_in.angle};
    wire parity_bit = ~(^ang_low);
    wire [15:0] angle_word = {1'b0, fault_summary, undervoltage_live, parity_bit,
                              sense_in.angle};
    wire [15:0] status_word = {TAG_STA, 2'b00, sense_in.die_index, sense_in.rot_dir, 1'b0,
                               action_done, boot_done, logic_selftest_running,
                               frontend_selftest_running, boot_active,
                               angle_valid};
    wire [15:0] error_word = {TAG_ERR, err_flags};
    wire [15:0] warn_word = {TAG_WARN, warn_flags};
    // Clear and trigger fields are write-only and read back as zero
    wire [15:0] ctrl_word = {action_select, 12'h000};

    wire [15:0] next_read_data = (reg_req_in.addr == ADDR_ANG) ? angle_word
                                 : (reg_req_in.addr == ADDR_STA) ? status_word
                                 : (reg_req_in.addr == ADDR_ERR) ? error_word
                                 : (reg_req_in.addr == ADDR_WARN) ? warn_word
                                 : (reg_req_in.addr == ADDR_CTRL) ? ctrl_word
                                 : 16'h0000;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            read_data_out <= 16'h0000;
        end else if (reg_req_in.rd) begin
            read_data_out <= next_read_data;
        end
    end

    assign fault_summary_out = fault_summary;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_angle_parity;
        @(posedge clock_in) disable iff (!rst_n_in)
        (reg_req_in.rd && reg_req_in.addr == ADDR_ANG) |=> (^read_data_out) == 1'b1;
    endproperty
    a_angle_parity: assert property (p_angle_parity)
        else $error("angle word parity is even");

    property p_done_clear;
        @(posedge clock_in) disable iff (!rst_n_in)
        (clear_done_flags && !action_complete && !boot_finish) |=> !action_done && !boot_done;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flags survived clear");

    // The host may leave an idle cycle between the read and the clear
    sequence s_cle_after_read;
        err_rd ##[1:2] (clear_error_flags && err_events == 12'h000);
    endsequence
    property p_err_clear;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_cle_after_read |=> (err_flags & $past(err_seen)) == 12'h000;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("read error bit not cleared");

    property p_err_survive;
        @(posedge clock_in) disable iff (!rst_n_in)
        (clear_error_flags && (err_flags & ~err_seen) != 12'h000)
        |=> (err_flags & $past(err_flags & ~err_seen)) == $past(err_flags & ~err_seen);
    endproperty
    a_err_survive: assert property (p_err_survive)
        else $error("unread error bit lost on clear");

    property p_err_latch;
        @(posedge clock_in) disable iff (!rst_n_in)
        (err_flags[7] && !clear_error_flags) |=> err_flags[7];
    endproperty
    a_err_latch: assert property (p_err_latch)
        else $error("error bit dropped without clear");

    sequence s_test_trig;
        start_logic && !start_frontend;
    endsequence
    property p_lbist_run;
        @(posedge clock_in) disable iff (!rst_n_in)
        s_test_trig |=> logic_selftest_running && !action_done && lstart;
    endproperty
    a_lbist_run: assert property (p_lbist_run)
        else $error("logic self-test did not start");

    // Checked on the read port so that a miswired status bit is caught too
    property p_aok;
        @(posedge clock_in) disable iff (!rst_n_in)
        (reg_req_in.rd && reg_req_in.addr == ADDR_STA)
        |=> read_data_out[STA_AOK_BIT]
            == ($past(sense_in.locked) && !read_data_out[STA_BOOT_BIT]);
    endproperty
    a_aok: assert property (p_aok)
        else $error("angle valid outside lock or boot");

    property p_boot_done;
        @(posedge clock_in) disable iff (!rst_n_in)
        boot_finish |=> boot_done && !boot_active ##1 !boot_active;
    endproperty
    a_boot_done: assert property (p_boot_done)
        else $error("boot done not set");

    property p_status_tag;
        @(posedge clock_in) disable iff (!rst_n_in)
        (reg_req_in.rd && reg_req_in.addr == ADDR_STA)
        |=> read_data_out[15:12] == TAG_STA && read_data_out[6] == 1'b0;
    endproperty
    a_status_tag: assert property (p_status_tag)
        else $error("status tag wrong");

    property p_ctrl_rd;
        @(posedge clock_in) disable iff (!rst_n_in)
        (reg_req_in.rd && reg_req_in.addr == ADDR_CTRL) |=> read_data_out[11:0] == 12'h000;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("write-only control fields read non-zero");

    // A reset also drops the running flag, so only a fall seen out of reset counts
    property p_act_done;
        @(posedge clock_in) disable iff (!rst_n_in)
        ($fell(logic_selftest_running) && $past(rst_n_in))
        |-> action_done || frontend_selftest_running;
    endproperty
    a_act_done: assert property (p_act_done)
        else $error("action done not set after logic self-test");

endmodule // angsr_regs

// [tb/angsr_test_model.sv]
`timescale 1ns/100ps
module angsr_test_model
    import angsr_pkg::*;
#(
    parameter int RUN_CYCLES = 8
)
(
    input wire logic clock_in,
    input wire logic logic_start_in,
    input wire logic frontend_start_in,
    input wire logic fail_in,
    output angsr_test_s test_out
);
    int lcnt = 0;
    int fcnt = 0;
    // Falling edge keeps the done pulses away from the block's sampling edge
    always @(negedge clock_in) begin
        test_out <= '0;
        if (logic_start_in) begin
            lcnt <= RUN_CYCLES;
        end else if (lcnt > 0) begin
            lcnt <= lcnt - 1;
            test_out.logic_done <= (lcnt == 1);
            test_out.logic_fail <= (lcnt == 1) && fail_in;
        end
        if (frontend_start_in) begin
            fcnt <= RUN_CYCLES;
        end else if (fcnt > 0) begin
            fcnt <= fcnt - 1;
            test_out.frontend_done <= (fcnt == 1);
            test_out.frontend_fail <= (fcnt == 1) && fail_in;
        end
    end
endmodule // angsr_test_model

// [tb/angsr_regs_bench.sv]
`timescale 1ns/100ps
module angsr_regs_bench
    import angsr_pkg::*;
;
    logic clk = 0;
    logic rst_n = 0;
    angsr_req_s req = '0;
    angsr_sense_s sense = '0;
    logic [11:0] emask = '0;
    logic [11:0] wmask = '0;
    angsr_test_s tst;
    logic [15:0] rdata;
    logic lstart, fstart, turns, hreset, fsum, fail;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [15:0] d;
    logic [3:0] sel;
    logic [15:0] ang_exp;
    angsr_regs u_angsr_regs (.clock_in(clk), .rst_n_in(rst_n), .reg_req_in(req),
        .read_data_out(rdata), .sense_in(sense), .error_mask_in(emask),
        .warning_mask_in(wmask), .test_in(tst), .logic_selftest_start_out(lstart),
        .frontend_selftest_start_out(fstart), .turns_reset_out(turns),
        .hard_reset_req_out(hreset), .fault_summary_out(fsum));
    angsr_test_model u_angsr_test_model (.clock_in(clk), .logic_start_in(lstart),
        .frontend_start_in(fstart), .fail_in(fail), .test_out(tst));
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(negedge clk);
        req.rd = 1;
        req.addr = a;
        @(negedge clk);
        req.rd = 0;
        v = rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge clk);
        req.wr = 1;
        req.addr = a;
        req.data = v;
        @(negedge clk);
        req.wr = 0;
    endtask
    task automatic do_reset;
        rst_n = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
    endtask
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fail = 0;
        sense.locked = 1;
        sense.rot_dir = 1;
        sense.die_index = 2'h2;
        do_reset();
        rchk(ADDR_ERR, 16'hA001);
        rchk(ADDR_STA, 16'h8282);
        rchk(8'h30, 16'h0000);
        @(negedge clk);
        sense.nvm_loaded = 1;
        @(negedge clk);
        sense.boot_tests_done = 1;
        repeat (3) @(negedge clk);
        rchk(ADDR_STA, 16'h8291);
        $display("test boot done");
        sense.angle = 12'h5A3;
        sense.supply_uv = 1;
        ang_exp = {2'b01, 1'b1, ~^{2'b11, 12'h5A3}, 12'h5A3};
        rchk(ADDR_ANG, ang_exp);
        chk({15'h0, fsum}, 16'h0001);
        emask = 12'h009;
        ang_exp = {3'b000, ~^12'h5A3, 12'h5A3};
        rchk(ADDR_ANG, ang_exp);
        chk({15'h0, fsum}, 16'h0000);
        emask = 12'h000;
        sense.supply_uv = 0;
        $display("test angle done");
        rchk(ADDR_ERR, 16'hA009);
        wr(ADDR_CTRL, 16'h0100);
        rchk(ADDR_ERR, 16'hA000);
        sense.lock_lost = 1;
        @(negedge clk);
        sense.lock_lost = 0;
        wr(ADDR_CTRL, 16'h0100);
        rchk(ADDR_ERR, 16'hA080);
        wr(ADDR_CTRL, 16'h0100);
        rchk(ADDR_ERR, 16'hA000);
        rchk(ADDR_CTRL, 16'h0000);
        $display("test error clear done");
        sense.warn_events[6] = 1;
        @(negedge clk);
        sense.warn_events[6] = 0;
        rchk(ADDR_ERR, 16'hA800);
        chk({15'h0, fsum}, 16'h0001);
        rchk(ADDR_WARN, 16'hB040);
        wr(ADDR_CTRL, 16'h0300);
        rchk(ADDR_WARN, 16'hB000);
        // The warning was still latched at the clear edge, so bit 11 set again
        rchk(ADDR_ERR, 16'hA800);
        wr(ADDR_CTRL, 16'h0100);
        rchk(ADDR_ERR, 16'hA000);
        $display("test warning done");
        sense.avg_fault = 1;
        sense.quad_fault = 1;
        sense.zero_to = 1;
        sense.nvm_uncorr = 1;
        sense.locked = 0;
        @(negedge clk);
        sense.avg_fault = 0;
        sense.quad_fault = 0;
        sense.zero_to = 0;
        sense.nvm_uncorr = 0;
        rchk(ADDR_ERR, 16'hA360);
        rchk(ADDR_STA, 16'h8290);
        sense.locked = 1;
        wr(ADDR_CTRL, 16'h0100);
        $display("test fault flags done");
        for (int i = 9; i <= 11; i++) begin
            sel = i[3:0];
            fail = (sel == SEL_LOGIC);
            wr(ADDR_CTRL, {sel, 4'h0, CODE_SELFTEST});
            chk({14'h0, lstart, fstart}, {14'h0, sel[1], sel[0]});
            rchk(ADDR_STA, {12'h829, sel[1], sel[0], 2'b01});
            repeat (12) @(negedge clk);
            rchk(ADDR_STA, 16'h82B1);
            rchk(ADDR_ERR, {4'hA, 1'b0, fail, 10'h000});
            wr(ADDR_CTRL, 16'h0100);
        end
        $display("test selftest done");
        wr(ADDR_CTRL, {SEL_TURNS, 4'h0, CODE_TURNS});
        chk({15'h0, turns}, 16'h0001);
        rchk(ADDR_STA, 16'h82B1);
        wr(ADDR_CTRL, 16'h0400);
        rchk(ADDR_STA, 16'h8281);
        wr(ADDR_CTRL, {SEL_HARD_RESET, 4'h0, CODE_HARD_RESET});
        chk({15'h0, hreset}, 16'h0001);
        // The system answers the request by resetting the block
        do_reset();
        rchk(ADDR_ERR, 16'hA001);
        $display("test actions done");
        finish_test;
    end
endmodule // angsr_regs_bench
